/* design/ubc_pkg.sv */
// Purpose: constants for the baud and frame configuration block
// Assumes: APB word addressing, 8-bit registers in low bits
// Notes: none
package ubc_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DIV_HIGH = 8'h00;
  localparam logic [7:0] OFS_DIV_LOW = 8'h04;
  localparam logic [7:0] OFS_FRAME_CTRL = 8'h08;
  localparam logic [7:0] OFS_SECOND_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_LIN_BREAK = 7;
  localparam int BIT_RX_EDGE = 6;
  localparam int BIT_LOOP = 7;
  localparam int BIT_HALT_WAIT = 6;
  localparam int BIT_RX_SRC = 5;
  localparam int BIT_NINE = 4;
  localparam int BIT_WAKE = 3;
  localparam int BIT_ILT = 2;
  localparam int BIT_PAR_EN = 1;
  localparam int BIT_PAR_ODD = 0;
  localparam int BIT_TX_ON = 3;
  localparam int BIT_RX_ON = 2;
  localparam int DIV_W = 13;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] HIGH_MASK = 8'hdf;
  localparam logic [7:0] IRQ_BITS = 8'hc0;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] IDLE_BITS_8 = 4'ha;
  localparam logic [3:0] IDLE_BITS_9 = 4'hb;
endpackage

/* design/ubc_top.sv */
// Purpose: baud generator, frame config, pin routing, irq for a uart
// Assumes: inputs synchronous to i_core_clk; pready always high
// Notes: sampling tick is 16x the bit rate
// Functional notes
// - high divisor write buffers the divisor bits, irq enable bits 7:6 take effect at once; working divisor changes on low write.
// - baud generator idle after reset until rx_on or tx_on written one.
// - divisor value zero stops the baud generator completely.
// - divisor 1..8191 gives bit rate of bus clock over sixteen times divisor.
// - high bits 4:0 are divisor bits 12:8, low register bits 7:0.
// - high bit 7 enables interrupt from lin break flag; the code also needs mask_reg bit 7 set before o_irq rises.
// - high bit 6 enables interrupt from receive edge flag; the code also needs mask_reg bit 6 set before o_irq rises.
// - loop select routes receiver from transmit path, not the receive pin.
// - source bit ignored without loop; loop with source zero is internal.
// - loop plus source gives single wire on the transmit pin.
// - halt_in_wait zero keeps clocks in wait; one freezes them.
// - nine-bit bit selects eight or nine data bits, LSB first.
// - wake bit picks idle-line or address-mark wakeup.
// - idle needs 10 or 11 high bit times, start per idle type bit.
// - parity enable generates and checks parity on the top data bit.
// - parity odd select picks even or odd, counting the parity bit.
// - tx_on must be one to transmit; then transmit pin is driven, in single wire only while i_tx_dir is high.
// - loop select releases the receive pin even with rx_on set.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ubc_top #(
  parameter int DIV_WIDTH = ubc_pkg::DIV_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cpu_wait,
  input wire logic i_lin_break_det,
  input wire logic i_rx_pin,
  input wire logic i_tx_pin_in,
  input wire logic i_tx_serial,
  input wire logic i_tx_dir,
  input wire logic i_rx_start_seen,
  input wire logic i_rx_stop_seen,
  input wire logic [8:0] i_tx_char,
  input wire logic [8:0] i_rx_char,
  output logic o_tx_pin_out,
  output logic o_tx_pin_oe,
  output logic o_rx_pin_used,
  output logic o_rx_serial,
  output logic o_sample_tick,
  output logic o_bit_tick,
  output logic o_clocks_run,
  output logic o_nine_bit,
  output logic o_wake_addr_mark,
  output logic o_idle_count_after_stop,
  output logic o_parity_enable,
  output logic o_parity_odd_select,
  output logic o_tx_parity_bit,
  output logic o_rx_parity_err,
  output logic o_idle_detected,
  output logic o_irq
);
  import ubc_pkg::*;

  // the divisor layout is fixed by the two 8-bit registers
  if (DIV_WIDTH != DIV_W) begin : g_width_check
    $error("divisor width must be 13");
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [7:0] div_high_reg, div_high_buf_reg, div_low_reg;
  logic [7:0] frame_reg, second_reg, status_reg, mask_reg;
  logic armed_reg;
  logic wr_en, rd_en, mapped;
  logic [12:0] divisor_value;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign mapped = hit(i_paddr, OFS_DIV_HIGH) || hit(i_paddr, OFS_DIV_LOW) ||
                  hit(i_paddr, OFS_FRAME_CTRL) || hit(i_paddr, OFS_SECOND_CTRL) ||
                  hit(i_paddr, OFS_IRQ_STATUS) || hit(i_paddr, OFS_IRQ_MASK);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (rd_en) begin
      case (1'b1)
        hit(i_paddr, OFS_DIV_HIGH): o_prdata[7:0] = div_high_buf_reg;
        hit(i_paddr, OFS_DIV_LOW): o_prdata[7:0] = div_low_reg;
        hit(i_paddr, OFS_FRAME_CTRL): o_prdata[7:0] = frame_reg;
        hit(i_paddr, OFS_SECOND_CTRL): o_prdata[7:0] = second_reg;
        hit(i_paddr, OFS_IRQ_STATUS): o_prdata[7:0] = status_reg;
        hit(i_paddr, OFS_IRQ_MASK): o_prdata[7:0] = mask_reg;
        default: o_prdata = 32'h0000_0000;
      endcase
    end
  end

  // high write lands in the buffer and in working bits 7:6; the rest of the working copy follows on low write
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_high_buf_reg <= RST_DIV_HIGH;
      div_high_reg <= RST_DIV_HIGH;
      div_low_reg <= RST_DIV_LOW;
    end else if (wr_en && hit(i_paddr, OFS_DIV_HIGH)) begin
      div_high_buf_reg <= i_pwdata[7:0] & HIGH_MASK;
      div_high_reg[7:6] <= i_pwdata[7:6];
    end else if (wr_en && hit(i_paddr, OFS_DIV_LOW)) begin
      div_low_reg <= i_pwdata[7:0];
      div_high_reg <= div_high_buf_reg;
    end
  end

  assign divisor_value = {div_high_reg[4:0], div_low_reg};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_reg <= RST_ZERO;
      second_reg <= RST_ZERO;
      mask_reg <= RST_ZERO;
    end else if (wr_en) begin
      if (hit(i_paddr, OFS_FRAME_CTRL)) frame_reg <= i_pwdata[7:0];
      if (hit(i_paddr, OFS_SECOND_CTRL)) second_reg <= i_pwdata[7:0];
      if (hit(i_paddr, OFS_IRQ_MASK)) mask_reg <= i_pwdata[7:0] & IRQ_BITS;
    end
  end

  // stays set: for a nonzero divisor the generator idles again only when frozen in wait
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_reg <= 1'b0;
    end else if (wr_en && hit(i_paddr, OFS_SECOND_CTRL) &&
                 (i_pwdata[BIT_TX_ON] || i_pwdata[BIT_RX_ON])) begin
      armed_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  logic [12:0] baud_cnt_reg;
  logic [3:0] sub_cnt_reg;
  logic baud_run, baud_hit;

  assign o_clocks_run = !(i_cpu_wait && frame_reg[BIT_HALT_WAIT]);
  assign baud_run = armed_reg && (divisor_value != 13'h0000) && o_clocks_run;
  assign baud_hit = baud_run && (baud_cnt_reg >= divisor_value - 13'h0001);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      baud_cnt_reg <= 13'h0000;
      o_sample_tick <= 1'b0;
    end else if (!baud_run) begin
      baud_cnt_reg <= baud_cnt_reg; // frozen in wait, cleared below if off
      if (divisor_value == 13'h0000 || !armed_reg) baud_cnt_reg <= 13'h0000;
      o_sample_tick <= 1'b0;
    end else if (baud_hit) begin
      baud_cnt_reg <= 13'h0000;
      o_sample_tick <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 13'h0001;
      o_sample_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sub_cnt_reg <= 4'h0;
      o_bit_tick <= 1'b0;
    end else begin
      o_bit_tick <= baud_hit && (sub_cnt_reg == OVERSAMPLE_LAST);
      if (!armed_reg || divisor_value == 13'h0000) sub_cnt_reg <= 4'h0;
      else if (baud_hit) sub_cnt_reg <= sub_cnt_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  logic loop_sel, single_wire, rx_serial_prev_reg;
  assign loop_sel = frame_reg[BIT_LOOP];
  assign single_wire = loop_sel && frame_reg[BIT_RX_SRC];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_serial <= 1'b1;
      o_tx_pin_out <= 1'b1;
      rx_serial_prev_reg <= 1'b1;
    end else begin
      o_tx_pin_out <= i_tx_serial;
      rx_serial_prev_reg <= o_rx_serial;
      if (!loop_sel) o_rx_serial <= i_rx_pin;
      else if (single_wire) o_rx_serial <= i_tx_pin_in;
      else o_rx_serial <= i_tx_serial;
    end
  end

  // single wire lets the transmitter turn the pin around
  assign o_tx_pin_oe = second_reg[BIT_TX_ON] && (!single_wire || i_tx_dir);
  assign o_rx_pin_used = second_reg[BIT_RX_ON] && !loop_sel;

  // ----------------------------------------------------------------
  // frame format and parity
  // ----------------------------------------------------------------
  logic [8:0] tx_body;
  assign o_nine_bit = frame_reg[BIT_NINE];
  assign o_wake_addr_mark = frame_reg[BIT_WAKE];
  assign o_idle_count_after_stop = frame_reg[BIT_ILT];
  assign o_parity_enable = frame_reg[BIT_PAR_EN];
  assign o_parity_odd_select = frame_reg[BIT_PAR_ODD];
  assign tx_body = o_nine_bit ? {1'b0, i_tx_char[7:0]} : {2'b00, i_tx_char[6:0]};

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tx_parity_bit <= 1'b0;
      o_rx_parity_err <= 1'b0;
    end else begin
      o_tx_parity_bit <= (^tx_body) ^ o_parity_odd_select;
      o_rx_parity_err <= o_parity_enable && ((o_nine_bit ? ^i_rx_char :
                         ^i_rx_char[7:0]) != o_parity_odd_select);
    end
  end

  // ----------------------------------------------------------------
  // idle detector
  // ----------------------------------------------------------------
  logic [3:0] idle_cnt_reg;
  logic idle_active_reg;
  logic idle_start;
  assign idle_start = o_idle_count_after_stop ? i_rx_stop_seen : i_rx_start_seen;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt_reg <= 4'h0;
      idle_active_reg <= 1'b0;
      o_idle_detected <= 1'b0;
    end else begin
      o_idle_detected <= 1'b0;
      if (idle_start) begin
        idle_cnt_reg <= 4'h0;
        idle_active_reg <= 1'b1;
      end else if (idle_active_reg && !o_rx_serial) begin
        idle_cnt_reg <= 4'h0;
      end else if (idle_active_reg && o_bit_tick) begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
        if (idle_cnt_reg + 4'h1 == (o_nine_bit ? IDLE_BITS_9 : IDLE_BITS_8)) begin
          o_idle_detected <= 1'b1;
          idle_active_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [7:0] event_set, irq_enable;
  assign event_set = {i_lin_break_det,
                      second_reg[BIT_RX_ON] && rx_serial_prev_reg && !o_rx_serial,
                      6'h00};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= RST_ZERO;
    end else begin
      status_reg <= (status_reg & ~((wr_en && hit(i_paddr, OFS_IRQ_STATUS)) ?
                    i_pwdata[7:0] : 8'h00)) | event_set;
    end
  end

  assign irq_enable = {div_high_reg[BIT_LIN_BREAK], div_high_reg[BIT_RX_EDGE], 6'h00};
  assign o_irq = |(status_reg & irq_enable & mask_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  div_hold_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !(wr_en && hit(i_paddr, OFS_DIV_LOW)) |=> $stable(divisor_value))
    else $error("divisor changed without low write");
  div_load_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (wr_en && hit(i_paddr, OFS_DIV_LOW)) |=>
    divisor_value == {$past(div_high_buf_reg[4:0]), $past(i_pwdata[7:0])})
    else $error("divisor not assembled from buffer and low");
  idle_unarmed_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !armed_reg |-> !o_sample_tick && !o_bit_tick)
    else $error("tick before generator enabled");
  zero_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (divisor_value == 13'h0000) |=> !o_sample_tick && baud_cnt_reg == 13'h0000)
    else $error("generator active with zero divisor");
  tick_space_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (o_sample_tick && divisor_value == 13'h0002 && $stable(divisor_value) &&
     baud_run) |=> !o_sample_tick ##1 (o_sample_tick || !baud_run))
    else $error("tick spacing wrong for divisor two");
  irq_lin_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (status_reg[BIT_LIN_BREAK] && div_high_reg[BIT_LIN_BREAK] && mask_reg[BIT_LIN_BREAK])
    |-> o_irq)
    else $error("lin break irq missing");
  irq_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!div_high_reg[BIT_LIN_BREAK] && !div_high_reg[BIT_RX_EDGE]) |-> !o_irq)
    else $error("irq without enable");
  loop_route_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (loop_sel && !frame_reg[BIT_RX_SRC]) |=> o_rx_serial == $past(i_tx_serial))
    else $error("loop does not feed receiver from transmitter");
  wire_route_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    single_wire |=> o_rx_serial == $past(i_tx_pin_in))
    else $error("single wire routing wrong");
  rx_release_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    loop_sel |-> !o_rx_pin_used)
    else $error("receive pin held in loop mode");
  tx_drive_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !second_reg[BIT_TX_ON] |-> !o_tx_pin_oe)
    else $error("transmit pin driven while off");
  wait_freeze_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (i_cpu_wait && frame_reg[BIT_HALT_WAIT]) |=> !o_sample_tick)
    else $error("clocks ran in wait while halted");
  par_even_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!o_nine_bit && !o_parity_odd_select) |=> o_tx_parity_bit == ^$past(i_tx_char[6:0]))
    else $error("even parity bit wrong");
endmodule
`default_nettype wire

/* test/ubc_partner.sv */
// Purpose: remote serial node that sends frames on the receive line
// Assumes: bit time is a whole number of bench clock cycles
// Notes: line idles high, like a pulled-up wire
`timescale 1ns/1ps
`default_nettype none
module ubc_partner #(
  parameter int BIT_CYC = 48
) (
  input wire logic i_clk,
  output logic o_line,
  output logic [8:0] o_char,
  output logic o_start,
  output logic o_stop
);
  initial begin
    o_line = 1'b1;
    o_char = 9'h000;
    o_start = 1'b0;
    o_stop = 1'b0;
  end
  // ----------------------------------------------------------------
  // frame sender
  // ----------------------------------------------------------------
  task automatic bit_out(input logic v);
    @(posedge i_clk);
    o_line <= v;
    repeat (BIT_CYC - 1) @(posedge i_clk);
  endtask
  // bad flips the parity bit so the receiver must flag it
  task automatic send(input logic [8:0] d, input logic nine, input logic par_en,
      input logic odd, input logic bad);
    logic [8:0] c;
    int nb;
    c = d;
    nb = nine ? 9 : 8;
    if (!nine) c[8] = 1'b0;
    if (par_en) c[nb - 1] = (nine ? ^d[7:0] : ^d[6:0]) ^ odd ^ bad;
    bit_out(1'b0);
    o_start <= 1'b1;
    @(posedge i_clk);
    o_start <= 1'b0;
    for (int i = 0; i < nb; i++) bit_out(c[i]);
    o_char <= c;
    bit_out(1'b1);
    o_stop <= 1'b1;
    @(posedge i_clk);
    o_stop <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* test/ubc_top_tb_top.sv */
// Purpose: self-checking bench for the baud and frame config block
// Assumes: divisor kept small so bit times stay short
// Notes: partner node drives the receive line; rx_flip inverts it
`timescale 1ns/1ps
`default_nettype none
module ubc_top_tb_top;
  import ubc_pkg::*;
  logic clk, rst, psel, penable, pwrite, cpu_wait, lin_brk, rx_flip, tx_pin_in, tx_ser, tx_dir;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] tx_char, p_char;
  logic pready, pslverr, p_line, p_start, p_stop, tx_out, tx_oe, rx_used, rx_ser, s_tick;
  logic b_tick, clk_run, nine, wake, idle_count_after_stop, pe, podd, tx_par, rx_perr, idle, irq;
  wire logic [3:0] evs;
  int miscompares, samples_checked, n;
  assign evs = {1'b1, idle, b_tick, s_tick};
  ubc_top ubc_top_i (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cpu_wait(cpu_wait), .i_lin_break_det(lin_brk),
    .i_rx_pin(p_line ^ rx_flip), .i_tx_pin_in(tx_pin_in), .i_tx_serial(tx_ser),
    .i_tx_dir(tx_dir), .i_rx_start_seen(p_start), .i_rx_stop_seen(p_stop),
    .i_tx_char(tx_char), .i_rx_char(p_char), .o_tx_pin_out(tx_out), .o_tx_pin_oe(tx_oe),
    .o_rx_pin_used(rx_used), .o_rx_serial(rx_ser), .o_sample_tick(s_tick),
    .o_bit_tick(b_tick), .o_clocks_run(clk_run), .o_nine_bit(nine), .o_wake_addr_mark(wake),
    .o_idle_count_after_stop(idle_count_after_stop), .o_parity_enable(pe), .o_parity_odd_select(podd),
    .o_tx_parity_bit(tx_par), .o_rx_parity_err(rx_perr), .o_idle_detected(idle), .o_irq(irq));
  ubc_partner #(.BIT_CYC(48)) ubc_partner_i (.i_clk(clk), .o_line(p_line), .o_char(p_char),
    .o_start(p_start), .o_stop(p_stop));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int k;
    k = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    if (k >= 50) miscompares++;
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, q, exp);
  endtask
  // counts cnt events until stop event; sync first aligns on a stop event
  task automatic span(input int stp, input int cnt, input logic sync, output int c);
    int k;
    k = 0;
    c = 0;
    if (sync) begin
      @(posedge clk);
      while (evs[stp] !== 1'b1 && k < 3000) begin
        @(posedge clk);
        k++;
      end
    end
    @(posedge clk);
    while (evs[stp] !== 1'b1 && k < 6000) begin
      if (evs[cnt] === 1'b1) c++;
      @(posedge clk);
      k++;
    end
    if (k >= 6000) miscompares++;
  endtask
  task automatic gap(output int p);
    span(0, 3, 1'b1, p);
    span(0, 3, 1'b1, p);
    p = p + 1;
  endtask
  task automatic count_ticks(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (s_tick === 1'b1) c++;
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rdchk("div_high", OFS_DIV_HIGH, {24'h0, RST_DIV_HIGH});
    rdchk("div_low", OFS_DIV_LOW, {24'h0, RST_DIV_LOW});
    count_ticks(64, n);
    chk("ticks_unarmed", n, 0);
    wr(OFS_SECOND_CTRL, 32'h04);
    gap(n);
    chk("gap_reset", n, RST_DIV_LOW);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped_err", e, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_div();
    wr(OFS_DIV_LOW, 32'h03);
    gap(n);
    chk("gap_3", n, 3);
    span(1, 0, 1'b1, n);
    // the 16th sample tick shares its edge with the bit tick, so span misses it
    chk("ticks_per_bit", n + 1, 16);
    wr(OFS_DIV_HIGH, 32'h01);
    rdchk("high_buf", OFS_DIV_HIGH, 32'h01);
    gap(n);
    chk("gap_buffered", n, 3);
    wr(OFS_DIV_LOW, 32'h02);
    gap(n);
    chk("gap_258", n, 258);
    wr(OFS_DIV_HIGH, 32'h00);
    wr(OFS_DIV_LOW, 32'h00);
    repeat (2) @(posedge clk);
    count_ticks(600, n);
    chk("ticks_div0", n, 0);
    wr(OFS_DIV_LOW, 32'h02);
    gap(n);
    chk("gap_2", n, 2);
    wr(OFS_DIV_LOW, 32'h03);
    $display("test divisor done");
  endtask
  task automatic t_frame();
    for (int b = 0; b < 8; b++) begin
      wr(OFS_FRAME_CTRL, 32'h1 << b);
      rdchk("frame_rb", OFS_FRAME_CTRL, 32'h1 << b);
      chk("frame_outs", {nine, wake, idle_count_after_stop, pe, podd}, (32'h1 << b) & 32'h1f);
    end
    for (int m = 0; m < 4; m++) begin
      wr(OFS_FRAME_CTRL, {27'h0, m[1], 2'b00, 1'b1, m[0]});
      for (int c = 0; c < 512; c += 73) begin
        tx_char <= c[8:0];
        repeat (2) @(posedge clk);
        chk("tx_parity", tx_par, (m[1] ? ^c[7:0] : ^c[6:0]) ^ m[0]);
      end
    end
    $display("test frame done");
  endtask
  task automatic t_route();
    wr(OFS_SECOND_CTRL, 32'h0c);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_FRAME_CTRL, {24'h0, m[1], 1'b0, m[0], 5'h00});
      for (int v = 0; v < 16; v++) begin
        {tx_dir, tx_pin_in, tx_ser, rx_flip} <= v[3:0];
        repeat (2) @(posedge clk);
        chk("rx_serial", rx_ser, m[1] ? (m[0] ? v[2] : v[1]) : !v[0]);
        chk("pins", {rx_used, tx_oe, tx_out}, {!m[1], !(m[1] && m[0]) || v[3], v[1]});
      end
    end
    wr(OFS_SECOND_CTRL, 32'h04);
    @(posedge clk);
    chk("tx_off", tx_oe, 1'b0);
    wr(OFS_SECOND_CTRL, 32'h0c);
    wr(OFS_FRAME_CTRL, 32'h00);
    {tx_dir, tx_pin_in, tx_ser, rx_flip} <= 4'h0;
    $display("test route done");
  endtask
  task automatic t_link();
    wr(OFS_FRAME_CTRL, 32'h03);
    for (int b = 0; b < 2; b++) begin
      ubc_partner_i.send(9'h035, 1'b0, 1'b1, 1'b1, b[0]);
      @(posedge clk);
      chk("rx_perr_8", rx_perr, b[0]);
    end
    wr(OFS_FRAME_CTRL, 32'h12);
    for (int b = 0; b < 2; b++) begin
      ubc_partner_i.send(9'h1a5, 1'b1, 1'b1, 1'b0, b[0]);
      @(posedge clk);
      chk("rx_perr_9", rx_perr, b[0]);
    end
    wr(OFS_FRAME_CTRL, 32'h04);
    ubc_partner_i.send(9'h0ff, 1'b0, 1'b0, 1'b0, 1'b0);
    span(2, 1, 1'b0, n);
    chk("idle_after_stop", n >= 9 && n <= 11, 1'b1);
    wr(OFS_FRAME_CTRL, 32'h00);
    ubc_partner_i.send(9'h0ff, 1'b0, 1'b0, 1'b0, 1'b0);
    span(2, 1, 1'b0, n);
    chk("idle_after_start", n < 4, 1'b1);
    $display("test link done");
  endtask
  task automatic t_irq();
    wr(OFS_IRQ_STATUS, 32'hff);
    lin_brk <= 1'b1;
    @(posedge clk);
    lin_brk <= 1'b0;
    rdchk("status_lin", OFS_IRQ_STATUS, 32'h80);
    chk("irq_no_en", irq, 1'b0);
    wr(OFS_IRQ_MASK, 32'hc0);
    wr(OFS_DIV_HIGH, 32'h80);
    @(posedge clk);
    chk("irq_lin", irq, 1'b1);
    wr(OFS_IRQ_STATUS, 32'h80);
    @(posedge clk);
    chk("irq_lin_clr", irq, 1'b0);
    wr(OFS_DIV_HIGH, 32'h40);
    rx_flip <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq_edge", irq, 1'b1);
    rdchk("status_edge", OFS_IRQ_STATUS, 32'h40);
    wr(OFS_DIV_HIGH, 32'h00);
    @(posedge clk);
    chk("irq_edge_off", irq, 1'b0);
    rx_flip <= 1'b0;
    $display("test irq done");
  endtask
  task automatic t_wait();
    wr(OFS_FRAME_CTRL, 32'h40);
    cpu_wait <= 1'b1;
    repeat (2) @(posedge clk);
    chk("clocks_frozen", clk_run, 1'b0);
    count_ticks(30, n);
    chk("ticks_frozen", n, 0);
    wr(OFS_FRAME_CTRL, 32'h00);
    @(posedge clk);
    chk("clocks_in_wait", clk_run, 1'b1);
    count_ticks(30, n);
    chk("ticks_in_wait", n, 10);
    cpu_wait <= 1'b0;
    $display("test wait done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, psel, penable, pwrite, cpu_wait, lin_brk, rx_flip, tx_pin_in, tx_ser, tx_dir} = 10'h200;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_char = 9'h000;
    miscompares = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_div();
    t_frame();
    t_route();
    t_link();
    t_irq();
    t_wait();
    stop_test();
  end
  // whole run needs roughly 6k cycles
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
